/* common/tobd_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Summary of operation
// - Enabled break clears primary output enable asynchronously
// - Primary enable gates outputs by channel enables
// - Auto re-enable sets primary enable on update
// - Break polarity selects active pin level
// - Break enable gates pin and clock-failure input
// - Run off-state governs complementary channels when enabled
// - Idle off-state governs channels when primary disabled
// - Level one locks idle, break, auto, dead-time
// - Level two adds polarity and off-state locks
// - Level three adds compare mode/shadow locks
// - Lock level written once after reset
// - Code 0xx: dead time code times base
// - Code 10x: (64+low six) times two bases
// - Code 110: (32+low five) times eight bases
// - Code 111: (32+low five) times sixteen bases
// - Burst count n gives n+1 accesses
// - Burst start selects base plus four times value
// - Each burst access targets next word
// - Hardware steps burst index, redirects buffer accesses
`ifndef TOBD_REGS_SVH
`define TOBD_REGS_SVH
// Byte offsets
`define TOBD_OFF_GRD 8'h44
`define TOBD_OFF_DMA 8'h48
`define TOBD_OFF_BUF 8'h4c
`define TOBD_OFF_CHAN 8'h50
`define TOBD_OFF_CMP 8'h54
`define TOBD_OFF_STAT 8'h58
// Protection control fields
`define TOBD_PEN_BIT 15
`define TOBD_AREN_BIT 14
`define TOBD_BPOL_BIT 13
`define TOBD_BEN_BIT 12
`define TOBD_ROFF_BIT 11
`define TOBD_IOFF_BIT 10
`define TOBD_LVL_LSB 8
`define TOBD_DT_LSB 0
// Burst config fields
`define TOBD_CNT_LSB 8
`define TOBD_START_LSB 0
// Channel control fields
`define TOBD_MEN_LSB 0
`define TOBD_CEN_LSB 4
`define TOBD_MPOL_LSB 8
`define TOBD_CPOL_LSB 12
`define TOBD_MIDL_LSB 16
`define TOBD_CIDL_LSB 20
// Compare control fields
`define TOBD_CMODE_LSB 0
`define TOBD_CSHAD_LSB 12
// Status fields
`define TOBD_ST_BRK_BIT 0
`define TOBD_ST_LOCK_BIT 1
`define TOBD_ST_IDX_LSB 8
// Reset values
`define TOBD_RST_GRD 16'h0000
`define TOBD_RST_DMA 16'h0000
// Dead-time base and clock, in ns
`define TOBD_DTBASE_NS 10
`define TOBD_CLK_NS 10
`define TOBD_DT_BASE_CYC (`TOBD_DTBASE_NS / `TOBD_CLK_NS)
// AXI responses
`define TOBD_RESP_OKAY 2'b00
`define TOBD_RESP_SLVERR 2'b10
`endif

/* common/tobd_pkg.sv */
// Types shared by the output protection and burst block
package tobd_pkg;
    // Register selected by a decoded address
    typedef enum logic [2:0] {RID_NONE, RID_GRD, RID_DMA, RID_BUF, RID_CHAN, RID_CMP,
        RID_STAT} tobd_rid_t;
    // Protection control fields, primary enable kept apart
    typedef struct packed {
        logic aren;
        logic brk_pol;
        logic brk_en;
        logic roff;
        logic ioff;
        logic [1:0] lock_lvl;
        logic lock_done;
        logic [7:0] dt_code;
    } tobd_grd_t;
    // Burst setup and running index
    typedef struct packed {
        logic [4:0] cnt;
        logic [4:0] start;
        logic [4:0] idx;
    } tobd_burst_t;
    // Channel enables, polarities, idle levels, compare setup
    typedef struct packed {
        logic [3:0] main_en;
        logic [2:0] compl_en;
        logic [3:0] main_pol;
        logic [2:0] compl_pol;
        logic [3:0] main_idle;
        logic [2:0] compl_idle;
        logic [11:0] cmp_mode;
        logic [3:0] cmp_shadow;
    } tobd_chan_t;
    // Bus slave state
    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic bvalid;
        logic rvalid;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tobd_axi_t;
    // Clocked state of the block, primary enable and outputs kept apart
    typedef struct packed {
        tobd_axi_t axi;
        tobd_grd_t grd;
        tobd_burst_t burst;
        tobd_chan_t chan;
        logic [1:0] brk_s;
        logic [1:0] cfm_s;
        logic [3:0] ref_q;
        logic [2:0][9:0] dt_cnt;
    } tobd_state_t;
    // Output stage value
    typedef struct packed {
        logic [3:0] main_out;
        logic [3:0] main_oe;
        logic [2:0] compl_out;
        logic [2:0] compl_oe;
    } tobd_out_t;
endpackage

/* logic/tobd_top.sv */
// Break, dead time, output protection and DMA burst redirect with AXI4-Lite slave
`timescale 1ns/1ps
`include "tobd_regs.svh"
module tobd_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Kernel side
    input wire logic update_event,
    input wire logic [3:0] channel_ref,
    // Break sources, asynchronous
    input wire logic break_pin,
    input wire logic clock_failure_monitor,
    // Power stage outputs
    output logic [3:0] channel_main_out,
    output logic [3:0] channel_main_oe,
    output logic [2:0] channel_compl_out,
    output logic [2:0] channel_compl_oe,
    output logic primary_output_enable
);

    // Clocked state and its next value
    tobd_pkg::tobd_state_t s_q;
    tobd_pkg::tobd_state_t s_d;
    // Primary enable, kept apart for its asynchronous clear
    logic pen_q;
    logic pen_d;
    // Output stage
    tobd_pkg::tobd_out_t o_q;
    tobd_pkg::tobd_out_t o_d;
    // Break seen straight from the pins
    logic brk_async;
    // Break seen through synchronisers
    logic brk_sync;
    // Software write to the primary enable bit
    logic pen_wr;
    logic pen_wr_val;

    // Address decode of a byte address, upper bits must be zero
    function automatic tobd_pkg::tobd_rid_t decode(input logic [31:0] a);
        tobd_pkg::tobd_rid_t r;
        r = tobd_pkg::RID_NONE;
        if (a[31:8] == 24'h000000)
        begin
            case (a[7:0])
                `TOBD_OFF_GRD: r = tobd_pkg::RID_GRD;
                `TOBD_OFF_DMA: r = tobd_pkg::RID_DMA;
                `TOBD_OFF_BUF: r = tobd_pkg::RID_BUF;
                `TOBD_OFF_CHAN: r = tobd_pkg::RID_CHAN;
                `TOBD_OFF_CMP: r = tobd_pkg::RID_CMP;
                `TOBD_OFF_STAT: r = tobd_pkg::RID_STAT;
                default: r = tobd_pkg::RID_NONE;
            endcase
        end
        return r;
    endfunction

    // Register reached through the buffer port at the current index
    function automatic tobd_pkg::tobd_rid_t burst_target(input tobd_pkg::tobd_burst_t b);
        logic [5:0] word;
        tobd_pkg::tobd_rid_t r;
        word = {1'b0, b.start} + {1'b0, b.idx};
        r = decode({24'h000000, word, 2'b00});
        // The buffer port never reaches itself, so no loop
        if (r == tobd_pkg::RID_BUF)
        begin
            r = tobd_pkg::RID_NONE;
        end
        return r;
    endfunction

    // Index after one access: walks 0..count then wraps
    function automatic logic [4:0] next_idx(input tobd_pkg::tobd_burst_t b);
        return (b.idx >= b.cnt) ? 5'h00 : 5'(b.idx + 5'h01);
    endfunction

    // Dead-time length in clock cycles from the 8-bit code
    function automatic logic [9:0] dt_cycles(input logic [7:0] c);
        logic [9:0] base;
        casez (c[7:5])
            3'b0??: base = {2'b00, c};
            3'b10?: base = 10'(({4'h0, c[5:0]} + 10'd64) * 10'd2);
            3'b110: base = 10'(({5'h00, c[4:0]} + 10'd32) * 10'd8);
            default: base = 10'(({5'h00, c[4:0]} + 10'd32) * 10'd16);
        endcase
        return 10'(base * 10'(`TOBD_DT_BASE_CYC));
    endfunction

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Readback value of a register
    function automatic logic [31:0] readback(input tobd_pkg::tobd_rid_t r,
        input tobd_pkg::tobd_state_t s, input logic pen, input logic brk);
        logic [31:0] v;
        v = 32'h00000000;
        case (r)
            tobd_pkg::RID_GRD:
            begin
                v[`TOBD_PEN_BIT] = pen;
                v[`TOBD_AREN_BIT] = s.grd.aren;
                v[`TOBD_BPOL_BIT] = s.grd.brk_pol;
                v[`TOBD_BEN_BIT] = s.grd.brk_en;
                v[`TOBD_ROFF_BIT] = s.grd.roff;
                v[`TOBD_IOFF_BIT] = s.grd.ioff;
                v[`TOBD_LVL_LSB +: 2] = s.grd.lock_lvl;
                v[`TOBD_DT_LSB +: 8] = s.grd.dt_code;
            end
            tobd_pkg::RID_DMA:
            begin
                v[`TOBD_CNT_LSB +: 5] = s.burst.cnt;
                v[`TOBD_START_LSB +: 5] = s.burst.start;
            end
            tobd_pkg::RID_CHAN:
            begin
                v[`TOBD_MEN_LSB +: 4] = s.chan.main_en;
                v[`TOBD_CEN_LSB +: 3] = s.chan.compl_en;
                v[`TOBD_MPOL_LSB +: 4] = s.chan.main_pol;
                v[`TOBD_CPOL_LSB +: 3] = s.chan.compl_pol;
                v[`TOBD_MIDL_LSB +: 4] = s.chan.main_idle;
                v[`TOBD_CIDL_LSB +: 3] = s.chan.compl_idle;
            end
            tobd_pkg::RID_CMP:
            begin
                v[`TOBD_CMODE_LSB +: 12] = s.chan.cmp_mode;
                v[`TOBD_CSHAD_LSB +: 4] = s.chan.cmp_shadow;
            end
            tobd_pkg::RID_STAT:
            begin
                v[`TOBD_ST_BRK_BIT] = brk;
                v[`TOBD_ST_LOCK_BIT] = s.grd.lock_done;
                v[`TOBD_ST_IDX_LSB +: 5] = s.burst.idx;
            end
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    // Raw-pin break; glitches here only ever turn outputs off
    assign brk_async = s_q.grd.brk_en & ((break_pin == s_q.grd.brk_pol)
        | clock_failure_monitor);
    // Same condition after two flops, for clocked decisions
    assign brk_sync = s_q.grd.brk_en & ((s_q.brk_s[1] == s_q.grd.brk_pol)
        | s_q.cfm_s[1]);

    // Next-state logic: bus slave, register writes, burst, dead time
    always_comb
    begin
        logic ar_hs;
        logic wr_go;
        tobd_pkg::tobd_rid_t rid;
        logic [31:0] wv;
        logic [9:0] dtc;
        ar_hs = 1'b0;
        wr_go = 1'b0;
        rid = tobd_pkg::RID_NONE;
        wv = 32'h00000000;
        dtc = dt_cycles(s_q.grd.dt_code);
        s_d = s_q;
        pen_wr = 1'b0;
        pen_wr_val = 1'b0;
        // Break synchronisers
        s_d.brk_s = {s_q.brk_s[0], break_pin};
        s_d.cfm_s = {s_q.cfm_s[0], clock_failure_monitor};
        // Capture write address and data in either order
        if (s_q.axi.aw_rdy && s_axi_awvalid)
        begin
            s_d.axi.aw_rdy = 1'b0;
            s_d.axi.awaddr = s_axi_awaddr[7:0];
            s_d.axi.bresp = (s_axi_awaddr[31:8] == 24'h000000) ? `TOBD_RESP_OKAY
                : `TOBD_RESP_SLVERR;
        end
        if (s_q.axi.w_rdy && s_axi_wvalid)
        begin
            s_d.axi.w_rdy = 1'b0;
            s_d.axi.wdata = s_axi_wdata;
            s_d.axi.wstrb = s_axi_wstrb;
        end
        // Read takes the cycle; a pending write waits one cycle for it
        ar_hs = s_q.axi.ar_rdy & s_axi_arvalid;
        wr_go = !s_q.axi.aw_rdy && !s_q.axi.w_rdy && !s_q.axi.bvalid && !ar_hs;
        // Register write
        if (wr_go)
        begin
            rid = (s_q.axi.bresp == `TOBD_RESP_OKAY)
                ? decode({24'h000000, s_q.axi.awaddr}) : tobd_pkg::RID_NONE;
            if (rid == tobd_pkg::RID_BUF)
            begin
                rid = burst_target(s_q.burst);
                s_d.burst.idx = next_idx(s_q.burst);
            end
            wv = merge(readback(rid, s_q, pen_q, brk_sync), s_q.axi.wdata, s_q.axi.wstrb);
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp = (rid == tobd_pkg::RID_NONE) ? `TOBD_RESP_SLVERR
                : `TOBD_RESP_OKAY;
            case (rid)
                tobd_pkg::RID_GRD:
                begin
                    pen_wr = 1'b1;
                    pen_wr_val = wv[`TOBD_PEN_BIT];
                    // Level is taken from the first write only
                    s_d.grd.lock_done = 1'b1;
                    if (!s_q.grd.lock_done)
                    begin
                        s_d.grd.lock_lvl = wv[`TOBD_LVL_LSB +: 2];
                    end
                    // Checked against the level in force before this write
                    if (s_q.grd.lock_lvl == 2'b00)
                    begin
                        s_d.grd.aren = wv[`TOBD_AREN_BIT];
                        s_d.grd.brk_pol = wv[`TOBD_BPOL_BIT];
                        s_d.grd.brk_en = wv[`TOBD_BEN_BIT];
                        s_d.grd.dt_code = wv[`TOBD_DT_LSB +: 8];
                    end
                    if (s_q.grd.lock_lvl < 2'b10)
                    begin
                        s_d.grd.roff = wv[`TOBD_ROFF_BIT];
                        s_d.grd.ioff = wv[`TOBD_IOFF_BIT];
                    end
                end
                tobd_pkg::RID_DMA:
                begin
                    s_d.burst.cnt = wv[`TOBD_CNT_LSB +: 5];
                    s_d.burst.start = wv[`TOBD_START_LSB +: 5];
                    // New setup restarts the walk
                    s_d.burst.idx = 5'h00;
                end
                tobd_pkg::RID_CHAN:
                begin
                    s_d.chan.main_en = wv[`TOBD_MEN_LSB +: 4];
                    s_d.chan.compl_en = wv[`TOBD_CEN_LSB +: 3];
                    if (s_q.grd.lock_lvl < 2'b10)
                    begin
                        s_d.chan.main_pol = wv[`TOBD_MPOL_LSB +: 4];
                        s_d.chan.compl_pol = wv[`TOBD_CPOL_LSB +: 3];
                    end
                    if (s_q.grd.lock_lvl == 2'b00)
                    begin
                        s_d.chan.main_idle = wv[`TOBD_MIDL_LSB +: 4];
                        s_d.chan.compl_idle = wv[`TOBD_CIDL_LSB +: 3];
                    end
                end
                tobd_pkg::RID_CMP:
                begin
                    if (s_q.grd.lock_lvl != 2'b11)
                    begin
                        s_d.chan.cmp_mode = wv[`TOBD_CMODE_LSB +: 12];
                        s_d.chan.cmp_shadow = wv[`TOBD_CSHAD_LSB +: 4];
                    end
                end
                // Status is read-only, unmapped already answered
                default:
                begin
                end
            endcase
        end
        // Write response retires, slave is ready again
        if (s_q.axi.bvalid && s_axi_bready)
        begin
            s_d.axi.bvalid = 1'b0;
            s_d.axi.aw_rdy = 1'b1;
            s_d.axi.w_rdy = 1'b1;
        end
        // Register read
        if (ar_hs)
        begin
            rid = decode(s_axi_araddr);
            if (rid == tobd_pkg::RID_BUF)
            begin
                rid = burst_target(s_q.burst);
                s_d.burst.idx = next_idx(s_q.burst);
            end
            s_d.axi.ar_rdy = 1'b0;
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rdata = readback(rid, s_q, pen_q, brk_sync);
            s_d.axi.rresp = (rid == tobd_pkg::RID_NONE) ? `TOBD_RESP_SLVERR
                : `TOBD_RESP_OKAY;
        end
        else if (s_q.axi.rvalid && s_axi_rready)
        begin
            s_d.axi.rvalid = 1'b0;
            s_d.axi.ar_rdy = 1'b1;
        end
        // Dead-time counters restart on every reference edge
        s_d.ref_q = channel_ref;
        for (int i = 0; i < 3; i++)
        begin
            if (channel_ref[i] != s_q.ref_q[i])
            begin
                s_d.dt_cnt[i] = dtc;
            end
            else if (s_q.dt_cnt[i] != 10'h000)
            begin
                s_d.dt_cnt[i] = 10'(s_q.dt_cnt[i] - 10'h001);
            end
        end
    end

    // Primary enable: break wins over software and auto re-enable
    always_comb
    begin
        if (brk_sync)
        begin
            pen_d = 1'b0;
        end
        else if (pen_wr)
        begin
            pen_d = pen_wr_val;
        end
        else if (s_q.grd.aren && update_event)
        begin
            pen_d = 1'b1;
        end
        else
        begin
            pen_d = pen_q;
        end
    end

    // Output stage: dead time, polarity, run and idle off-state
    always_comb
    begin
        logic act_m;
        logic act_c;
        logic en_m;
        logic en_c;
        act_m = 1'b0;
        act_c = 1'b0;
        en_m = 1'b0;
        en_c = 1'b0;
        o_d = '0;
        for (int i = 0; i < 4; i++)
        begin
            // Channel 3 has no complementary output and no dead time
            if (i < 3)
            begin
                act_m = s_q.ref_q[i] & (s_q.dt_cnt[i] == 10'h000);
                act_c = !s_q.ref_q[i] & (s_q.dt_cnt[i] == 10'h000);
            end
            else
            begin
                act_m = s_q.ref_q[i];
                act_c = 1'b0;
            end
            if (pen_q)
            begin
                // Run state: channel enables, run off-state for pairs
                en_m = s_q.chan.main_en[i] & ((i == 3) | s_q.grd.roff);
                en_c = (i < 3) & s_q.chan.compl_en[i % 3] & s_q.grd.roff;
                o_d.main_out[i] = en_m & (act_m ^ s_q.chan.main_pol[i]);
                if (i < 3)
                begin
                    o_d.compl_out[i] = en_c & (act_c ^ s_q.chan.compl_pol[i]);
                end
            end
            else
            begin
                // Idle state: idle off-state decides, idle levels shown
                en_m = s_q.chan.main_en[i] & s_q.grd.ioff;
                en_c = (i < 3) & s_q.chan.compl_en[i % 3] & s_q.grd.ioff;
                o_d.main_out[i] = en_m & s_q.chan.main_idle[i];
                if (i < 3)
                begin
                    o_d.compl_out[i] = en_c & s_q.chan.compl_idle[i];
                end
            end
            o_d.main_oe[i] = en_m;
            if (i < 3)
            begin
                o_d.compl_oe[i] = en_c;
            end
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.axi.aw_rdy <= 1'b1;
            s_q.axi.w_rdy <= 1'b1;
            s_q.axi.ar_rdy <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Primary enable and outputs clear without a clock on break
    always_ff @(posedge clk or posedge brk_async)
    begin
        if (brk_async)
        begin
            pen_q <= 1'b0;
            o_q <= '0;
        end
        else if (reset)
        begin
            pen_q <= 1'b0;
            o_q <= '0;
        end
        else
        begin
            pen_q <= pen_d;
            o_q <= o_d;
        end
    end

    // Ports straight from flops
    assign s_axi_awready = s_q.axi.aw_rdy;
    assign s_axi_wready = s_q.axi.w_rdy;
    assign s_axi_bvalid = s_q.axi.bvalid;
    assign s_axi_bresp = s_q.axi.bresp;
    assign s_axi_arready = s_q.axi.ar_rdy;
    assign s_axi_rvalid = s_q.axi.rvalid;
    assign s_axi_rdata = s_q.axi.rdata;
    assign s_axi_rresp = s_q.axi.rresp;
    assign channel_main_out = o_q.main_out;
    assign channel_main_oe = o_q.main_oe;
    assign channel_compl_out = o_q.compl_out;
    assign channel_compl_oe = o_q.compl_oe;
    assign primary_output_enable = pen_q;

endmodule

/* bench/tobd_sva.sv */
// Port relations of the protection and burst block
`timescale 1ns/1ps
module tobd_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Kernel side and outputs
    input wire logic update_event,
    input wire logic [3:0] channel_main_out,
    input wire logic [3:0] channel_main_oe,
    input wire logic [2:0] channel_compl_out,
    input wire logic [2:0] channel_compl_oe,
    input wire logic primary_output_enable
);
    // One domain, so one clock and one disable
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write unanswered");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read unanswered");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
        && s_axi_awready && s_axi_wready) else $error("write slot not freed");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        && s_axi_arready) else $error("read slot not freed");
    wr_slot_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write slot open too early");
    unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h58
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
    out_gate_a: assert property ((channel_main_out & ~channel_main_oe) == 4'h0
        && (channel_compl_out & ~channel_compl_oe) == 3'h0) else $error("undriven output");
    primary_output_enable_src_a: assert property ($rose(primary_output_enable) |-> $past(update_event)
        || s_axi_bvalid || !s_axi_awready) else $error("enable set without cause");
endmodule
bind tobd_top tobd_sva u_sva (.*);

/* bench/tobd_stage.sv */
// Gate driver model: break pin source and leg overlap flag
`timescale 1ns/1ps
module tobd_stage (
    // Commands from the bench
    input wire logic trip,
    input wire logic pol,
    // High and low switch drive per leg
    input wire logic [2:0] hi,
    input wire logic [2:0] lo,
    // Fault side
    output logic break_pin,
    output logic shoot
);
    // Pin idles at the inverse of its active level
    assign break_pin = trip ? pol : ~pol;
    // Both switches of a leg on is a short
    assign shoot = |(hi & lo);
endmodule

/* bench/tobd_bench.sv */
// Self-checking bench for the protection and burst block
`timescale 1ns/1ps
module tobd_bench;
    // Bus, kernel and power side signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, update_event = 0, clock_failure_monitor = 0, break_pin;
    logic primary_output_enable, trip = 0, pol = 0, shoot;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] channel_ref = '0, channel_main_out, channel_main_oe;
    logic [2:0] channel_compl_out, channel_compl_oe;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] dc[4] = '{8'h05, 8'h81, 8'hc1, 8'he0};
    int de[4] = '{5, 130, 264, 512};
    int num_errors = 0, compares = 0, cyc = 0, n;
    tobd_top DUT (.*);
    tobd_stage u_stage (.trip(trip), .pol(pol), .hi(channel_main_out[2:0] & channel_main_oe[2:0]),
        .lo(channel_compl_out & channel_compl_oe), .break_pin(break_pin), .shoot(shoot));
    initial forever #5 clk = ~clk;
    task automatic give_verdict();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Hang guard, well above the longest dead-time walk
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    // Results are matched against the oldest note
    always @(posedge clk)
    begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (shoot) chk(34'h1, 34'h0);
    end
    task automatic rst();
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic [1:0] e);
        bq.push_back(e);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {8'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= {24'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask
    task automatic upd();
        update_event <= 1'b1;
        @(posedge clk);
        update_event <= 1'b0;
        @(posedge clk);
    endtask
    // Count samples with both leg-0 outputs low after a rising reference
    task automatic dtm(input int e);
        channel_ref <= {3'($urandom), 1'b1};
        n = 0;
        do @(posedge clk); while (channel_main_out[0] | channel_compl_out[0]);
        while (!(channel_main_out[0] | channel_compl_out[0]))
        begin
            n++;
            @(posedge clk);
        end
        chk({1'b0, channel_main_out[0], 32'(n)}, {2'b01, 32'(e)});
    endtask
    initial
    begin
        void'($urandom(32));
        rst();
        rd(8'h44, 34'h0);
        rd(8'h60, {2'b10, 32'h0});
        wr(8'h44, 24'h5905, 2'b00);
        wr(8'h44, 24'h83ff, 2'b00);
        rd(8'h44, 34'hd105);
        wr(8'h50, 24'h110011, 2'b00);
        rd(8'h50, 34'h11);
        wr(8'h48, 24'h0211, 2'b00);
        rd(8'h4c, 34'hd105);
        rd(8'h4c, 34'h0211);
        rd(8'h4c, {2'b10, 32'h0});
        rd(8'h4c, 34'hd105);
        clock_failure_monitor <= 1'b1;
        #1 chk({33'h0, primary_output_enable}, 34'h0);
        @(posedge clk);
        clock_failure_monitor <= 1'b0;
        // Dead time per code range, fresh reset each time
        foreach (dc[i])
        begin
            rst();
            channel_ref <= 4'h0;
            wr(8'h50, 24'h11, 2'b00);
            wr(8'h44, {16'hc8, dc[i]}, 2'b00);
            repeat (600) @(posedge clk);
            dtm(de[i]);
        end
        trip <= 1'b1;
        @(posedge clk);
        chk({33'h0, primary_output_enable}, 34'h1);
        trip <= 1'b0;
        wr(8'h44, 24'hf000, 2'b00);
        rd(8'h44, 34'h7000);
        pol <= 1'b1;
        repeat (3) @(posedge clk);
        upd();
        chk({33'h0, primary_output_enable}, 34'h1);
        trip <= 1'b1;
        #1 chk({29'h0, channel_main_oe, primary_output_enable}, 34'h0);
        @(posedge clk);
        upd();
        chk({33'h0, primary_output_enable}, 34'h0);
        // Top lock level freezes off-state and compare fields
        rst();
        wr(8'h44, 24'h0300, 2'b00);
        wr(8'h44, 24'h0c00, 2'b00);
        rd(8'h44, 34'h0300);
        wr(8'h54, 24'hffff, 2'b00);
        rd(8'h54, 34'h0);
        give_verdict();
    end
endmodule
